// File: system_clock_control_regs.sv
// System-control register window: clock ratio, prescalers, gates, low power, watchdog
// Overview of operation
// - Every register in the window ignores accesses unless protected access is enabled.
// - Ratio register resets only on the external device reset pin.
// - Debug reset leaves the ratio register unchanged; clock multiplication changes only if the strap pin, resampled during it, has moved.
// - Multiplication ratio comes from the four low bits of the ratio register.
// - CPU input clock and system clock out always share one frequency.
// - Ratio 0 bypasses giving half input; 1..10 give n/2; 11..15 reserved.
// - Multiplier-disable pin low at reset gives CPU clock equal to input clock.
`include "sysctl_params.svh"
`timescale 1ns/1ps
`default_nettype none
module system_clock_control_regs #(
    parameter int SETTLE_CYCLES = `SETTLE_SYS_CYCLES
) (
    input  wire logic                 clk_sys_in,
    input  wire logic                 rst_n_in,
    input  wire logic                 device_reset_pin_n_in,
    input  wire logic                 protected_access_enable_in,
    input  wire logic                 multiplier_disable_pin_in,
    input  wire logic [15:0]          addr_in,
    input  wire logic [15:0]          wdata_in,
    input  wire logic                 write_in,
    input  wire logic                 read_in,
    input  wire logic [7:0]           watchdog_count_in,
    output var  logic [15:0]          rdata_out,
    output var  sysctl_pkg::clk_mode_t clk_mode_out,
    output var  logic [3:0]           ratio_n_out,
    output var  logic [4:0]           cpu_clk_num_out,
    output var  logic [4:0]           sys_clk_out_num_out,
    output var  logic                 ratio_settling_out,
    output var  logic [15:0]          fast_prescale_out,
    output var  logic [15:0]          slow_prescale_out,
    output var  logic [15:0]          clk_gate_out,
    output var  logic [15:0]          low_power_a_out,
    output var  logic [15:0]          low_power_b_out,
    output var  logic [15:0]          watchdog_control_out,
    output var  logic                 watchdog_key_strobe_out,
    output var  logic [15:0]          watchdog_key_out
);
    import sysctl_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // Request capture and pin synchronisation
    reg_req_t   req;
    logic       dev_rst_n;
    logic       pll_dis_n;
    logic       pll_dis_latched_n;
    logic       in_reset_d;
    logic [15:0] fast_prescale;
    logic [15:0] slow_prescale;
    logic [15:0] clk_gate;
    logic [15:0] lpm_a;
    logic [15:0] lpm_b;
    logic [15:0] ratio;
    logic [15:0] status;
    logic [15:0] wd_key;
    logic [15:0] wd_ctrl;
    logic [17:0] settle_cnt;
    logic        wr_ok;

    assign req = '{write: write_in, read: read_in, addr: addr_in, wdata: wdata_in};

    // Device reset pin crosses in from outside the clock domain
    pin_sync3 #(
        .RESET_VAL (1'b0)
    ) u_rst_sync (
        .clk_sys_in (clk_sys_in),
        .rst_n_in   (1'b1),
        .pin_in     (device_reset_pin_n_in),
        .level_out  (dev_rst_n)
    );

    // Multiplier-disable strap pin; left out of reset so that it already carries the
    // strap level while reset is held, which is when the strap has to be sampled
    pin_sync3 #(
        .RESET_VAL (1'b1)
    ) u_dis_sync (
        .clk_sys_in (clk_sys_in),
        .rst_n_in   (1'b1),
        .pin_in     (multiplier_disable_pin_in),
        .level_out  (pll_dis_n)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Helper functions

    // True for a documented register word; everything else in the window is reserved
    function automatic logic is_mapped(input logic [15:0] a);
        case (a)
            `OFF_FAST_PRESCALE, `OFF_SLOW_PRESCALE, `OFF_CLK_GATE, `OFF_LPM_A,
            `OFF_LPM_B, `OFF_RATIO, `OFF_STATUS, `OFF_WD_COUNT, `OFF_WD_KEY,
            `OFF_WD_CTRL: is_mapped = 1'b1;
            default: is_mapped = 1'b0;
        endcase
    endfunction

    // Twice the output frequency, in units of the input clock
    function automatic logic [4:0] clk_num(input clk_mode_t m, input logic [3:0] n);
        case (m)
            CLK_DISABLED:   clk_num = 5'h02;
            CLK_BYPASSED:   clk_num = 5'h01;
            CLK_MULTIPLIED: clk_num = {1'b0, n};
            default:        clk_num = 5'h01;
        endcase
    endfunction

    // Writes count only with protected access open and the address decoded
    assign wr_ok = req.write && protected_access_enable_in && is_mapped(req.addr);

    ////////////////////////////////////////////////////////////////////////////////
    // Strap capture: the latch follows the synchronised pin while either reset is held
    // and freezes one cycle after release, so a late strap change cannot move the clock
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in || !dev_rst_n) begin
            in_reset_d        <= 1'b1;
            pll_dis_latched_n <= pll_dis_n;
        end else begin
            in_reset_d <= 1'b0;
            if (in_reset_d) begin
                pll_dis_latched_n <= pll_dis_n;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Ratio register: only the device reset pin restores it, so a debug reset on
    // rst_n_in keeps the chosen multiplication running
    always_ff @(posedge clk_sys_in) begin
        if (!dev_rst_n) begin
            ratio <= `RST_RATIO;
        end else if (wr_ok && req.addr == `OFF_RATIO) begin
            ratio <= {12'h000, req.wdata[`RATIO_MSB:0]};
        end
    end

    // Settle timer restarts on each ratio write; software waits it out before the watchdog
    always_ff @(posedge clk_sys_in) begin
        if (!dev_rst_n) begin
            settle_cnt <= '0;
        end else if (wr_ok && req.addr == `OFF_RATIO) begin
            settle_cnt <= 18'(SETTLE_CYCLES);
        end else if (settle_cnt != '0) begin
            settle_cnt <= settle_cnt - 18'h00001;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Other control registers follow either reset source, one process per register so
    // that a decode slip on one word cannot disturb its neighbours
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in || !dev_rst_n) begin
            fast_prescale <= `RST_FAST_PRESCALE;
        end else if (wr_ok && req.addr == `OFF_FAST_PRESCALE) begin
            fast_prescale <= req.wdata;
        end
    end

    // Slow peripheral prescaler
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in || !dev_rst_n) begin
            slow_prescale <= `RST_SLOW_PRESCALE;
        end else if (wr_ok && req.addr == `OFF_SLOW_PRESCALE) begin
            slow_prescale <= req.wdata;
        end
    end

    // Peripheral clock gates
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in || !dev_rst_n) begin
            clk_gate <= `RST_CLK_GATE;
        end else if (wr_ok && req.addr == `OFF_CLK_GATE) begin
            clk_gate <= req.wdata;
        end
    end

    // Low-power control, first word
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in || !dev_rst_n) begin
            lpm_a <= `RST_LPM_A;
        end else if (wr_ok && req.addr == `OFF_LPM_A) begin
            lpm_a <= req.wdata;
        end
    end

    // Low-power control, second word
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in || !dev_rst_n) begin
            lpm_b <= `RST_LPM_B;
        end else if (wr_ok && req.addr == `OFF_LPM_B) begin
            lpm_b <= req.wdata;
        end
    end

    // Status: only the writable bits move; the others keep their reset level
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in || !dev_rst_n) begin
            status <= `RST_STATUS;
        end else if (wr_ok && req.addr == `OFF_STATUS) begin
            status <= (status & ~`STATUS_RW_MASK) | (req.wdata & `STATUS_RW_MASK);
        end
    end

    // Watchdog control
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in || !dev_rst_n) begin
            wd_ctrl <= `RST_WD_CTRL;
        end else if (wr_ok && req.addr == `OFF_WD_CTRL) begin
            wd_ctrl <= req.wdata;
        end
    end

    // Key writes pass on to the watchdog as a one-cycle strobe
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in || !dev_rst_n) begin
            wd_key                  <= `RST_WD_KEY;
            watchdog_key_strobe_out <= 1'b0;
        end else begin
            watchdog_key_strobe_out <= wr_ok && req.addr == `OFF_WD_KEY;
            if (wr_ok && req.addr == `OFF_WD_KEY) begin
                wd_key <= req.wdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read port: data one cycle after the strobe; reserved words and closed access read zero
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            rdata_out <= 16'h0000;
        end else if (req.read && protected_access_enable_in) begin
            case (req.addr)
                `OFF_FAST_PRESCALE: rdata_out <= fast_prescale;
                `OFF_SLOW_PRESCALE: rdata_out <= slow_prescale;
                `OFF_CLK_GATE:      rdata_out <= clk_gate;
                `OFF_LPM_A:         rdata_out <= lpm_a;
                `OFF_LPM_B:         rdata_out <= lpm_b;
                `OFF_RATIO:         rdata_out <= ratio;
                `OFF_STATUS:        rdata_out <= status;
                `OFF_WD_COUNT:      rdata_out <= {8'h00, watchdog_count_in};
                `OFF_WD_KEY:        rdata_out <= wd_key;
                `OFF_WD_CTRL:       rdata_out <= wd_ctrl;
                default:            rdata_out <= 16'h0000;
            endcase
        end else begin
            rdata_out <= 16'h0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Clock mode: disabled strap wins, then bypass for ratio 0, reserved ratios hold bypass.
    // Only the device reset pin clears it: a debug reset must not move the running
    // multiplication, so it shares the ratio register's reset source.
    always_ff @(posedge clk_sys_in) begin
        if (!dev_rst_n) begin
            clk_mode_out        <= CLK_BYPASSED;
            ratio_n_out         <= 4'h0;
            cpu_clk_num_out     <= 5'h01;
            sys_clk_out_num_out <= 5'h01;
        end else begin
            if (!pll_dis_latched_n) begin
                clk_mode_out    <= CLK_DISABLED;
                cpu_clk_num_out <= clk_num(CLK_DISABLED, 4'h0);
                sys_clk_out_num_out <= clk_num(CLK_DISABLED, 4'h0);
            end else if (ratio[3:0] == `RATIO_BYPASS || ratio[3:0] > `RATIO_MAX) begin
                clk_mode_out    <= CLK_BYPASSED;
                cpu_clk_num_out <= clk_num(CLK_BYPASSED, 4'h0);
                sys_clk_out_num_out <= clk_num(CLK_BYPASSED, 4'h0);
            end else begin
                clk_mode_out    <= CLK_MULTIPLIED;
                cpu_clk_num_out <= clk_num(CLK_MULTIPLIED, ratio[3:0]);
                sys_clk_out_num_out <= clk_num(CLK_MULTIPLIED, ratio[3:0]);
            end
            ratio_n_out <= ratio[3:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Register contents toward the clock, low-power and watchdog logic
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            fast_prescale_out    <= `RST_FAST_PRESCALE;
            slow_prescale_out    <= `RST_SLOW_PRESCALE;
            clk_gate_out         <= `RST_CLK_GATE;
            low_power_a_out      <= `RST_LPM_A;
            low_power_b_out      <= `RST_LPM_B;
            watchdog_control_out <= `RST_WD_CTRL;
            watchdog_key_out     <= `RST_WD_KEY;
            ratio_settling_out   <= 1'b0;
        end else begin
            fast_prescale_out    <= fast_prescale;
            slow_prescale_out    <= slow_prescale;
            clk_gate_out         <= clk_gate;
            low_power_a_out      <= lpm_a;
            low_power_b_out      <= lpm_b;
            watchdog_control_out <= wd_ctrl;
            watchdog_key_out     <= wd_key;
            ratio_settling_out   <= settle_cnt != '0;
        end
    end
endmodule // system_clock_control_regs
`default_nettype wire

// File: sysctl_params.svh
// Register offsets, field positions, reset values and timing counts of the system-control block
`ifndef SYSCTL_PARAMS_SVH
`define SYSCTL_PARAMS_SVH

`define ADDR_W              16
`define DATA_W              16
`define OFF_FAST_PRESCALE   16'h701a
`define OFF_SLOW_PRESCALE   16'h701b
`define OFF_CLK_GATE        16'h701c
`define OFF_LPM_A           16'h701e
`define OFF_LPM_B           16'h701f
`define OFF_RATIO           16'h7021
`define OFF_STATUS          16'h7022
`define OFF_WD_COUNT        16'h7023
`define OFF_WD_KEY          16'h7025
`define OFF_WD_CTRL         16'h7029
`define WIN_LO              16'h7010
`define WIN_HI              16'h702f
`define RATIO_MSB           3
`define RATIO_BYPASS        4'h0
`define RATIO_MAX           4'ha
`define RST_FAST_PRESCALE   16'h0001
`define RST_SLOW_PRESCALE   16'h0002
`define RST_CLK_GATE        16'h0000
`define RST_LPM_A           16'h00fc
`define RST_LPM_B           16'h0000
`define RST_RATIO           16'h0000
`define RST_STATUS          16'h0005
`define RST_WD_KEY          16'h0000
`define RST_WD_CTRL         16'h0000
`define STATUS_RW_MASK      16'h0006
`define WD_DISABLE_BIT      6
`define SETTLE_IN_CYCLES    131072
`define INPUT_CLK_NS        10
`define SYS_CLK_NS          10
`define SETTLE_SYS_CYCLES   ((`SETTLE_IN_CYCLES * `INPUT_CLK_NS + `SYS_CLK_NS - 1) / `SYS_CLK_NS)

`endif

// File: sysctl_pkg.sv
// Types shared by the system-control register block
package sysctl_pkg;
    typedef struct packed {
        logic        write;
        logic        read;
        logic [15:0] addr;
        logic [15:0] wdata;
    } reg_req_t;

    typedef enum logic [1:0] {
        CLK_DISABLED,
        CLK_BYPASSED,
        CLK_MULTIPLIED
    } clk_mode_t;
endpackage

// File: pin_sync3.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module pin_sync3 #(
    parameter logic RESET_VAL = 1'b1
) (
    input  wire logic clk_sys_in,
    input  wire logic rst_n_in,
    input  wire logic pin_in,
    output var  logic level_out
);
    logic s1;
    logic s2;
    logic s3;

    // First stage feeds only the second; filtered level moves when stages two and three agree
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            s1        <= RESET_VAL;
            s2        <= RESET_VAL;
            s3        <= RESET_VAL;
            level_out <= RESET_VAL;
        end else begin
            s1 <= pin_in;
            s2 <= s1;
            s3 <= s2;
            if (s2 == s3) begin
                level_out <= s3;
            end
        end
    end
endmodule // pin_sync3
`default_nettype wire

// File: cpu_bfm.sv
// Behavioural CPU issuing word accesses to the system-control register window
`timescale 1ns/1ps
`default_nettype none
module cpu_bfm (
    input  wire logic        clk_sys_in,
    input  wire logic [15:0] rdata_in,
    output var  logic [15:0] addr_out,
    output var  logic [15:0] wdata_out,
    output var  logic        write_out,
    output var  logic        read_out,
    output var  logic        access_open_out
);
    // Bus idle and window closed until the bench opens it
    initial begin
        addr_out = 16'h0000;
        wdata_out = 16'h0000;
        write_out = 1'b0;
        read_out = 1'b0;
        access_open_out = 1'b0;
    end
    // Open or close the protected window; a closed window must make accesses harmless
    task automatic set_open(input logic v);
        @(posedge clk_sys_in);
        access_open_out <= v;
    endtask
    // Released lines carry inverted values so stale data never passes for valid data
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge clk_sys_in);
        write_out <= 1'b1;
        addr_out <= a;
        wdata_out <= d;
        @(posedge clk_sys_in);
        write_out <= 1'b0;
        addr_out <= ~a;
        wdata_out <= ~d;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [15:0] a, output logic [15:0] d);
        @(posedge clk_sys_in);
        read_out <= 1'b1;
        addr_out <= a;
        @(posedge clk_sys_in);
        read_out <= 1'b0;
        addr_out <= ~a;
        #1 d = rdata_in;
    endtask
endmodule // cpu_bfm
`default_nettype wire

// File: system_clock_control_regs_monitor.sv
// Concurrent checks on the ports of the system-control register block
`include "sysctl_params.svh"
`timescale 1ns/1ps
`default_nettype none
module system_clock_control_regs_monitor
    import sysctl_pkg::*;
(
    input wire logic                  clk_sys_in,
    input wire logic                  rst_n_in,
    input wire logic                  device_reset_pin_n_in,
    input wire logic                  protected_access_enable_in,
    input wire logic [15:0]           addr_in,
    input wire logic [15:0]           wdata_in,
    input wire logic                  write_in,
    input wire logic                  read_in,
    input wire logic [15:0]           rdata_out,
    input wire sysctl_pkg::clk_mode_t clk_mode_out,
    input wire logic [3:0]            ratio_n_out,
    input wire logic [4:0]            cpu_clk_num_out,
    input wire logic [4:0]            sys_clk_out_num_out,
    input wire logic [15:0]           fast_prescale_out,
    input wire logic                  watchdog_key_strobe_out
);
////////////////////////////////////////////////////////////////
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!rst_n_in);
    // Access protection, reserved words, ratio field and clock agreement
    property p_locked_write;
        write_in && !protected_access_enable_in && addr_in == `OFF_FAST_PRESCALE |-> ##2 $stable(fast_prescale_out);
    endproperty
    a_locked_write: assert property (p_locked_write) else $error("locked write landed");
    property p_locked_read;
        read_in && !protected_access_enable_in |=> rdata_out == 16'h0000;
    endproperty
    a_locked_read: assert property (p_locked_read) else $error("locked read leaked data");
    property p_reserved_read;
        read_in && protected_access_enable_in && addr_in inside {[16'h7010:16'h7019], 16'h701d,
        16'h7020, 16'h7024, [16'h7026:16'h7028], [16'h702a:16'h702f]} |=> rdata_out == 16'h0000;
    endproperty
    a_reserved_read: assert property (p_reserved_read) else $error("reserved word not zero");
    property p_ratio_field;
        write_in && protected_access_enable_in && addr_in == `OFF_RATIO
        |-> ##2 {12'h000, ratio_n_out} == ($past(wdata_in, 2) & 16'h000f);
    endproperty
    a_ratio_field: assert property (p_ratio_field) else $error("ratio field wrong");
    property p_same_freq;
        cpu_clk_num_out == sys_clk_out_num_out;
    endproperty
    a_same_freq: assert property (p_same_freq) else $error("clock rates differ");
    property p_mode_rate;
        cpu_clk_num_out == (clk_mode_out == CLK_MULTIPLIED ? {1'b0, ratio_n_out}
                           : clk_mode_out == CLK_BYPASSED ? 5'h01 : 5'h02);
    endproperty
    a_mode_rate: assert property (p_mode_rate) else $error("rate does not fit mode");
    property p_debug_keeps_ratio;
        @(posedge clk_sys_in) disable iff (!device_reset_pin_n_in) !rst_n_in |=> $stable(ratio_n_out);
    endproperty
    a_debug_keeps_ratio: assert property (p_debug_keeps_ratio) else $error("debug reset hit ratio");
    property p_key_strobe;
        write_in && protected_access_enable_in && addr_in == `OFF_WD_KEY |-> ##[1:2] watchdog_key_strobe_out;
    endproperty
    a_key_strobe: assert property (p_key_strobe) else $error("key strobe missing");
endmodule // system_clock_control_regs_monitor
////////////////////////////////////////////////////////////////
bind system_clock_control_regs system_clock_control_regs_monitor i_mon (
    .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .device_reset_pin_n_in(device_reset_pin_n_in),
    .protected_access_enable_in(protected_access_enable_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .write_in(write_in), .read_in(read_in), .rdata_out(rdata_out),
    .clk_mode_out(clk_mode_out), .ratio_n_out(ratio_n_out), .cpu_clk_num_out(cpu_clk_num_out),
    .sys_clk_out_num_out(sys_clk_out_num_out), .fast_prescale_out(fast_prescale_out),
    .watchdog_key_strobe_out(watchdog_key_strobe_out));
`default_nettype wire

// File: system_clock_control_regs_tb_top.sv
// Self-checking bench for the system-control register block
`include "sysctl_params.svh"
`timescale 1ns/1ps
`default_nettype none
module system_clock_control_regs_tb_top;
    import sysctl_pkg::*;
    localparam int SETTLE = 8;
    localparam logic [15:0] OFFS [14] = '{`OFF_FAST_PRESCALE, `OFF_SLOW_PRESCALE, `OFF_CLK_GATE,
        `OFF_LPM_A, `OFF_LPM_B, `OFF_RATIO, `OFF_STATUS, `OFF_WD_COUNT, `OFF_WD_KEY, `OFF_WD_CTRL,
        16'h7010, 16'h7020, 16'h7024, 16'h702f};
    localparam logic [15:0] EXPS [14] = '{`RST_FAST_PRESCALE, `RST_SLOW_PRESCALE, `RST_CLK_GATE,
        `RST_LPM_A, `RST_LPM_B, `RST_RATIO, `RST_STATUS, 16'h005a, `RST_WD_KEY, `RST_WD_CTRL,
        16'h0000, 16'h0000, 16'h0000, 16'h0000};
    logic        clk_sys_in = 1'b0;
    logic        rst_n_in = 1'b0;
    logic        pin_n = 1'b0;
    logic        mult_dis_n = 1'b1;
    logic [7:0]  wd_count = 8'h5a;
    logic [15:0] addr, wdata, rdata;
    logic        wr_s, rd_s, open;
    clk_mode_t   mode;
    logic [4:0]  cpu_num, sys_num;
    logic        settling;
    logic [15:0] slow_q, gate_q, lpa_q, lpb_q, wdc_q, key_q;
    int          error_cnt = 0;
    int          checks = 0;
////////////////////////////////////////////////////////////////
    always #5 clk_sys_in = ~clk_sys_in;
    cpu_bfm i_cpu_bfm (.clk_sys_in(clk_sys_in), .rdata_in(rdata), .addr_out(addr),
        .wdata_out(wdata), .write_out(wr_s), .read_out(rd_s), .access_open_out(open));
    system_clock_control_regs #(.SETTLE_CYCLES(SETTLE)) i_system_clock_control_regs (
        .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .device_reset_pin_n_in(pin_n),
        .protected_access_enable_in(open), .multiplier_disable_pin_in(mult_dis_n),
        .addr_in(addr), .wdata_in(wdata), .write_in(wr_s), .read_in(rd_s),
        .watchdog_count_in(wd_count), .rdata_out(rdata), .clk_mode_out(mode),
        .ratio_n_out(), .cpu_clk_num_out(cpu_num), .sys_clk_out_num_out(sys_num),
        .ratio_settling_out(settling), .fast_prescale_out(), .slow_prescale_out(slow_q),
        .clk_gate_out(gate_q), .low_power_a_out(lpa_q), .low_power_b_out(lpb_q),
        .watchdog_control_out(wdc_q), .watchdog_key_strobe_out(), .watchdog_key_out(key_q));
////////////////////////////////////////////////////////////////
    // Compare and count; case inequality so an unknown never matches
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
            error_cnt++;
        end
    endtask
    task automatic chk_rd(input logic [15:0] a, input logic [15:0] exp);
        logic [15:0] d;
        i_cpu_bfm.rd(a, d);
        chk(d, exp);
    endtask
    // Long hold lets the strap synchroniser settle before release
    task automatic pulse_reset(input logic dbg, input logic dev);
        @(posedge clk_sys_in);
        rst_n_in <= !dbg;
        pin_n <= !dev;
        repeat (8) @(posedge clk_sys_in);
        rst_n_in <= 1'b1;
        pin_n <= 1'b1;
        repeat (5) @(posedge clk_sys_in);
    endtask
    task automatic t_reset_values;
        foreach (OFFS[i]) chk_rd(OFFS[i], EXPS[i]);
        $display("test reset_values done");
    endtask
    // Closed window: read gives zero, writes vanish; then reserved word and key write
    task automatic t_locked;
        i_cpu_bfm.set_open(1'b0);
        i_cpu_bfm.wr(`OFF_RATIO, 16'h0005);
        i_cpu_bfm.wr(`OFF_FAST_PRESCALE, 16'hffff);
        chk_rd(`OFF_FAST_PRESCALE, 16'h0000);
        i_cpu_bfm.set_open(1'b1);
        chk_rd(`OFF_RATIO, 16'h0000);
        chk_rd(`OFF_FAST_PRESCALE, `RST_FAST_PRESCALE);
        i_cpu_bfm.wr(`OFF_WD_KEY, 16'h0055);
        i_cpu_bfm.wr(16'h7024, 16'hffff);
        chk_rd(16'h7024, 16'h0000);
        chk_rd(`OFF_WD_KEY, 16'h0055);
        $display("test locked done");
    endtask
    // Every ratio code, upper bits set to prove they are dropped
    task automatic t_ratio;
        logic [4:0] n;
        i_cpu_bfm.wr(`OFF_WD_CTRL, 16'h0001 << `WD_DISABLE_BIT);
        for (int k = 0; k < 16; k++) begin
            i_cpu_bfm.wr(`OFF_RATIO, {12'hfff, 4'(k)});
            chk_rd(`OFF_RATIO, {12'h000, 4'(k)});
            chk({15'h0, settling}, 16'h0001);
            repeat (SETTLE + 4) @(posedge clk_sys_in);
            #1;
            chk({15'h0, settling}, 16'h0000);
            n = (k == 0 || k > 10) ? 5'h01 : 5'(k);
            chk({11'h000, cpu_num}, {11'h000, n});
            chk({11'h000, sys_num}, {11'h000, n});
        end
        $display("test ratio done");
    endtask
    // Remaining registers: write, read back the status word only, then the copies toward the clock logic
    task automatic t_copies;
        i_cpu_bfm.wr(`OFF_SLOW_PRESCALE, 16'h1234);
        i_cpu_bfm.wr(`OFF_CLK_GATE, 16'h5678);
        i_cpu_bfm.wr(`OFF_LPM_A, 16'h9abc);
        i_cpu_bfm.wr(`OFF_LPM_B, 16'hdef0);
        i_cpu_bfm.wr(`OFF_STATUS, 16'hffff);
        chk_rd(`OFF_STATUS, `RST_STATUS | `STATUS_RW_MASK);
        chk(slow_q, 16'h1234);
        chk(gate_q, 16'h5678);
        chk(lpa_q, 16'h9abc);
        chk(lpb_q, 16'hdef0);
        chk(wdc_q, 16'h0001 << `WD_DISABLE_BIT);
        chk(key_q, 16'h0055);
        $display("test copies done");
    endtask
    task automatic t_resets;
        i_cpu_bfm.wr(`OFF_RATIO, 16'h0007);
        i_cpu_bfm.wr(`OFF_FAST_PRESCALE, 16'h0033);
        pulse_reset(1'b1, 1'b0);
        chk_rd(`OFF_RATIO, 16'h0007);
        chk_rd(`OFF_FAST_PRESCALE, `RST_FAST_PRESCALE);
        pulse_reset(1'b0, 1'b1);
        chk_rd(`OFF_RATIO, `RST_RATIO);
        $display("test resets done");
    endtask
    // Strap low at reset: ratio writes must not bring the multiplier back
    task automatic t_disabled;
        mult_dis_n <= 1'b0;
        pulse_reset(1'b1, 1'b0);
        i_cpu_bfm.wr(`OFF_RATIO, 16'h0007);
        repeat (SETTLE + 4) @(posedge clk_sys_in);
        #1;
        chk({14'h0000, mode}, {14'h0000, CLK_DISABLED});
        chk({11'h000, cpu_num}, 16'h0002);
        $display("test disabled done");
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
////////////////////////////////////////////////////////////////
    // Main sequence after both resets release together
    initial begin
        repeat (8) @(posedge clk_sys_in);
        rst_n_in <= 1'b1;
        pin_n <= 1'b1;
        repeat (5) @(posedge clk_sys_in);
        i_cpu_bfm.set_open(1'b1);
        t_reset_values;
        t_locked;
        t_ratio;
        t_copies;
        t_resets;
        t_disabled;
        tally_and_finish;
    end
    // Watchdog: tests need well under a thousand cycles
    initial begin
        #100000;
        error_cnt++;
        tally_and_finish;
    end
endmodule // system_clock_control_regs_tb_top
`default_nettype wire
